/* File: dgc_pkg.sv */
// Purpose: Shared constants and carriers for the DAC gain/offset code path
// Assumes: 20 MHz system clock
// Notes: Times kept in ns, cycle counts derived from them
package dgc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and resolutions
   localparam int DGC_WORD_W = 16;
   localparam int DGC_RES_WIDE = 16;
   localparam int DGC_RES_NARROW = 14;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [15:0] DGC_GAIN_RST = 16'h8000;
   localparam logic [15:0] DGC_OFFSET_RST = 16'h0000;
   localparam logic [15:0] DGC_CODE_RST = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int DGC_CLK_NS = 50;
   localparam int DGC_DACWAIT_NS = 2100;
   localparam int DGC_RSTWAIT_NS = 10000;
   localparam int DGC_RSTPULSE_NS = 100;
   // Least times round up
   localparam int DGC_GAP_CYC = (DGC_DACWAIT_NS + DGC_CLK_NS - 1) / DGC_CLK_NS;
   localparam int DGC_RSTWAIT_CYC = (DGC_RSTWAIT_NS + DGC_CLK_NS - 1) / DGC_CLK_NS;
   localparam int DGC_RSTPULSE_CYC = (DGC_RSTPULSE_NS + DGC_CLK_NS - 1) / DGC_CLK_NS;
   localparam int DGC_CNT_W = 8;
   localparam logic [7:0] DGC_CNT_MAX = 8'hFF;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic data_we;
      logic gain_we;
      logic offset_we;
      logic [15:0] wdata;
   } dgc_wr_t;

   typedef struct packed {
      logic valid;
      logic [15:0] code;
   } dgc_out_t;

   typedef enum logic [2:0] {
      DGC_BOOT = 3'b001,
      DGC_IDLE = 3'b010,
      DGC_GAP = 3'b100
   } dgc_state_t;

endpackage : dgc_pkg

/* File: dgc_cal_math.sv */
// Purpose: Gain and offset arithmetic for one data update, registered result
// Assumes: Operands held steady only during the start cycle
// Notes: Result appears in the cycle after start
`timescale 1ns/1ns
module dgc_cal_math
#(
   parameter int RES_BITS = 16
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   // Operands
   input wire logic start_i,
   input wire logic [15:0] data_i,
   input wire logic [15:0] gain_i,
   input wire logic [15:0] offset_i,
   // Result
   output logic [15:0] code_o,
   output logic done_o
);
   import dgc_pkg::*;

   localparam logic [RES_BITS:0] HALF = (RES_BITS + 1)'(1) << (RES_BITS - 1);
   localparam logic signed [RES_BITS+1:0] MAXC = (RES_BITS + 2)'((1 << RES_BITS) - 1);

   logic [RES_BITS-1:0] d_eff;
   logic [RES_BITS-1:0] g_eff;
   logic signed [RES_BITS-1:0] o_eff;
   logic [RES_BITS:0] factor;
   logic [2*RES_BITS:0] prod;
   logic signed [RES_BITS+1:0] sum;
   logic [15:0] code_next;

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic
   assign d_eff = data_i[15 -: RES_BITS];
   assign g_eff = gain_i[15 -: RES_BITS];
   assign o_eff = signed'(offset_i[15 -: RES_BITS]);
   assign factor = {1'b0, g_eff} + HALF;
   assign prod = {{(RES_BITS + 1){1'b0}}, d_eff} * {{RES_BITS{1'b0}}, factor};
   // Dropping the low half floors the product, no rounding
   assign sum = signed'({1'b0, prod[2*RES_BITS:RES_BITS]}) + (RES_BITS + 2)'(o_eff);

   always_comb
   begin
      code_next = 16'h0000;
      if (sum < 0)
      begin
         code_next = 16'h0000;
      end
      else if (sum > MAXC)
      begin
         code_next = 16'(MAXC);
      end
      else
      begin
         code_next = 16'(sum[RES_BITS-1:0]);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         code_o <= DGC_CODE_RST;
         done_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         done_o <= start_i;
         if (start_i)
         begin
            code_o <= code_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_unity;
      logic [15:0] d;
      (start_i && clk_en_i && gain_i == 16'h8000 && offset_i == 16'h0000, d = 16'(d_eff))
         |=> code_o == d;
   endproperty
   a_unity: assert property (p_unity) else $error("unity gain changed the code");

   property p_half;
      logic [15:0] d;
      (start_i && clk_en_i && gain_i == 16'h0000 && offset_i == 16'h0000, d = 16'(d_eff >> 1))
         |=> code_o == d;
   endproperty
   a_half: assert property (p_half) else $error("zero gain code did not halve");

   property p_sat_low;
      (start_i && clk_en_i && gain_i == 16'h8000 && offset_i[15]
         && $signed({2'b00, d_eff}) + (RES_BITS + 2)'(o_eff) < 0) |=> code_o == 16'h0000;
   endproperty
   a_sat_low: assert property (p_sat_low) else $error("negative sum not clamped to zero");

   property p_sat_high;
      (start_i && clk_en_i && gain_i == 16'hFFFF && data_i == 16'hFFFF && !offset_i[15])
         |=> code_o == 16'(MAXC);
   endproperty
   a_sat_high: assert property (p_sat_high) else $error("overflow not clamped to top code");

   property p_done;
      (start_i && clk_en_i) |=> done_o ##1 (!done_o || $past(start_i));
   endproperty
   a_done: assert property (p_done) else $error("result strobe timing wrong");

endmodule : dgc_cal_math

/* File: dgc_code_path.sv */
// Purpose: Calibrated internal code for a string DAC from data, gain and offset
// Assumes: Write strobes come from serial-interface logic on sys_clk_i
// Notes: Gain and offset are sampled only when a data word is applied
`timescale 1ns/1ns
module dgc_code_path
#(
   parameter int RES_BITS = dgc_pkg::DGC_RES_WIDE
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   // Writes from the serial interface
   input wire dgc_pkg::dgc_wr_t wr_i,
   // Converter code
   output dgc_pkg::dgc_out_t dac_o,
   // Status
   output logic ready_o,
   output logic early_wr_o
);
   import dgc_pkg::*;

   logic rst_meta_reg;
   logic rst_sync_n_reg;
   dgc_state_t state_reg;
   dgc_state_t state_next;
   logic [DGC_CNT_W-1:0] cnt_reg;
   logic [15:0] gain_reg;
   logic [15:0] offset_reg;
   logic [15:0] code_reg;
   logic valid_reg;
   logic early_reg;
   logic accept;
   logic cal_done;
   logic [15:0] cal_code;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release, assert at once, release after two edges
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_n_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_n_reg <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing
   assign ready_o = (state_reg == DGC_IDLE);
   assign accept = wr_i.data_we && ready_o;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         DGC_BOOT:
         begin
            // Host keeps quiet here; early traffic is dropped
            if (cnt_reg == DGC_CNT_W'(DGC_RSTWAIT_CYC - 1))
            begin
               state_next = DGC_IDLE;
            end
         end
         DGC_IDLE:
         begin
            if (accept)
            begin
               state_next = DGC_GAP;
            end
         end
         DGC_GAP:
         begin
            if (cnt_reg == DGC_CNT_W'(DGC_GAP_CYC - 1))
            begin
               state_next = DGC_IDLE;
            end
         end
         default:
         begin
            state_next = DGC_BOOT;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_sync_n_reg)
   begin
      if (!rst_sync_n_reg)
      begin
         state_reg <= DGC_BOOT;
      end
      else if (clk_en_i)
      begin
         state_reg <= state_next;
      end
   end

   // Counts cycles since reset release or since the last accepted update
   always_ff @(posedge sys_clk_i or negedge rst_sync_n_reg)
   begin
      if (!rst_sync_n_reg)
      begin
         cnt_reg <= '0;
      end
      else if (clk_en_i)
      begin
         if (accept)
         begin
            cnt_reg <= DGC_CNT_W'(1);
         end
         else if (cnt_reg != DGC_CNT_MAX)
         begin
            cnt_reg <= cnt_reg + DGC_CNT_W'(1);
         end
      end
   end

   // A refused data word is reported, not queued, so stale data never lands late
   always_ff @(posedge sys_clk_i or negedge rst_sync_n_reg)
   begin
      if (!rst_sync_n_reg)
      begin
         early_reg <= 1'b0;
      end
      else if (clk_en_i)
      begin
         early_reg <= wr_i.data_we && !ready_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Calibration values
   always_ff @(posedge sys_clk_i or negedge rst_sync_n_reg)
   begin
      if (!rst_sync_n_reg)
      begin
         gain_reg <= DGC_GAIN_RST;
         offset_reg <= DGC_OFFSET_RST;
      end
      else if (clk_en_i && state_reg != DGC_BOOT)
      begin
         if (wr_i.gain_we)
         begin
            gain_reg <= wr_i.wdata;
         end
         if (wr_i.offset_we)
         begin
            offset_reg <= wr_i.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic, gain and offset sampled with the data word
   dgc_cal_math #(
      .RES_BITS(RES_BITS)
   ) u_math (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_sync_n_reg),
      .clk_en_i(clk_en_i),
      .start_i(accept),
      .data_i(wr_i.wdata),
      .gain_i(gain_reg),
      .offset_i(offset_reg),
      .code_o(cal_code),
      .done_o(cal_done)
   );

   always_ff @(posedge sys_clk_i or negedge rst_sync_n_reg)
   begin
      if (!rst_sync_n_reg)
      begin
         code_reg <= DGC_CODE_RST;
         valid_reg <= 1'b0;
      end
      else if (clk_en_i)
      begin
         valid_reg <= cal_done;
         if (cal_done)
         begin
            code_reg <= cal_code;
         end
      end
   end

   assign dac_o.code = code_reg;
   assign dac_o.valid = valid_reg;
   assign early_wr_o = early_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [DGC_CNT_W-1:0] boot_cnt_reg;

   always_ff @(posedge sys_clk_i or negedge rst_sync_n_reg)
   begin
      if (!rst_sync_n_reg)
      begin
         boot_cnt_reg <= '0;
      end
      else if (clk_en_i && boot_cnt_reg != DGC_CNT_MAX)
      begin
         boot_cnt_reg <= boot_cnt_reg + DGC_CNT_W'(1);
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_sync_n_reg);

   property p_hold_code;
      !(cal_done && clk_en_i) |=> $stable(code_reg);
   endproperty
   a_hold_code: assert property (p_hold_code) else $error("code moved without a data write");

   property p_range;
      code_reg <= 16'((1 << RES_BITS) - 1);
   endproperty
   a_range: assert property (p_range) else $error("code beyond resolution");

   property p_gap;
      accept |-> cnt_reg >= DGC_CNT_W'(DGC_GAP_CYC);
   endproperty
   a_gap: assert property (p_gap) else $error("updates accepted too close together");

   property p_boot;
      ready_o |-> boot_cnt_reg >= DGC_CNT_W'(DGC_RSTWAIT_CYC);
   endproperty
   a_boot: assert property (p_boot) else $error("ready before reset wait elapsed");

   property p_latency;
      (accept && clk_en_i) ##1 clk_en_i |=> dac_o.valid && !ready_o;
   endproperty
   a_latency: assert property (p_latency) else $error("code not applied two cycles after write");

   c_update: cover property (accept ##2 dac_o.valid);
   c_refused: cover property (early_wr_o);
   c_back_to_back: cover property (accept ##[42:60] accept);
   c_gain_change: cover property (wr_i.gain_we && ready_o ##[1:5] accept);

endmodule : dgc_code_path

/* File: dgc_host_model.sv */
// Purpose: Host controller model writing data, gain and offset words
// Assumes: Driven from the bench by task calls just after a rising edge
// Notes: An impolite write skips the waits so refusals can be provoked
`timescale 1ns/1ns
module dgc_host_model
import dgc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Device status
   input wire logic ready_i,
   // Writes
   output dgc_wr_t wr_o
);
   int quiet_cyc;
   int gap_cyc;
   int timeouts = 0;
   initial wr_o = '0;
   ////////////////////////////////////////////////////////////////////////////
   // Time since reset release and since the last data word
   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         quiet_cyc <= 0;
      else if (quiet_cyc < 99999)
         quiet_cyc <= quiet_cyc + 1;
   end
   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         gap_cyc <= 9999;
      else if (wr_o.data_we)
         gap_cyc <= 1;
      else if (gap_cyc < 9999)
         gap_cyc <= gap_cyc + 1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One write, held for one edge; always lets an edge pass first
   task automatic put(input logic [2:0] we, input logic [15:0] v, input bit polite);
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      while (polite && n < 2000 && (ready_i !== 1'b1 || gap_cyc < DGC_GAP_CYC
             || quiet_cyc < DGC_RSTWAIT_CYC));
      // A wait that ran out is reported to the bench as a mismatch
      if (polite && n >= 2000)
         timeouts++;
      wr_o = {we, v};
      @(posedge sys_clk_i);
      #1;
      wr_o = '0;
   endtask : put
endmodule : dgc_host_model

/* File: dgc_code_path_tb.sv */
// Purpose: Self-checking bench for both builds of the code path
// Assumes: Expected codes are worked out from the transfer function
// Notes: Seed fixed so random calibration runs repeat
`timescale 1ns/1ns
module dgc_code_path_tb;
   import dgc_pkg::*;
   logic sys_clk_i;
   logic rst_n_i;
   logic clk_en;
   logic ready_w;
   logic early_w;
   logic early_n;
   dgc_wr_t wr;
   dgc_out_t dac_w;
   dgc_out_t dac_n;
   int failures;
   int samples_checked;
   logic [15:0] last_w;
   logic [15:0] gains [3] = '{16'h0000, 16'h8000, 16'hFFFF};
   logic [15:0] gexp [3] = '{16'h4000, 16'h8000, 16'hBFFF};

   dgc_code_path #(.RES_BITS(DGC_RES_WIDE)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .clk_en_i(clk_en), .wr_i(wr), .dac_o(dac_w), .ready_o(ready_w), .early_wr_o(early_w));
   dgc_code_path #(.RES_BITS(DGC_RES_NARROW)) dut_n (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .clk_en_i(clk_en), .wr_i(wr), .dac_o(dac_n), .ready_o(), .early_wr_o(early_n));
   dgc_host_model host (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ready_i(ready_w), .wr_o(wr));

   initial
   begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Expected code; saturation keeps a wrapped sum from reaching the string
   function automatic logic [15:0] exp_code(input logic [15:0] d, g, o, input int n);
      longint s;
      s = ((longint'(d >> (16 - n)) * ((longint'(1) << (n - 1)) + longint'(g >> (16 - n)))) >> n)
          + (longint'($signed(o)) >>> (16 - n));
      if (s < 0)
         s = 0;
      if (s > (longint'(1) << n) - 1)
         s = (longint'(1) << n) - 1;
      return s[15:0];
   endfunction : exp_code

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
         failures++;
      end
   endtask : check

   task automatic conclude();
      failures = failures + host.timeouts;
      $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////
   // Calibrate, confirm the output held, then apply one data word
   task automatic step(input logic [15:0] d, g, o);
      int n;
      host.put(3'b010, g, 1'b1);
      host.put(3'b001, o, 1'b1);
      check(dac_w.code, last_w);
      host.put(3'b100, d, 1'b1);
      n = 0;
      while (dac_w.valid !== 1'b1 && n < 4)
      begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      if (dac_w.valid !== 1'b1)
      begin
         failures++;
         conclude();
      end
      last_w = exp_code(d, g, o, DGC_RES_WIDE);
      check(dac_w.code, last_w);
      check(dac_n.code, exp_code(d, g, o, DGC_RES_NARROW));
   endtask : step
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n_i = 1'b0;
      clk_en = 1'b1;
      failures = 0;
      samples_checked = 0;
      last_w = DGC_CODE_RST;
      void'($urandom(33));
      repeat (20) @(posedge sys_clk_i);
      #1;
      rst_n_i = 1'b1;
      repeat (4) @(posedge sys_clk_i);
      #1;
      // Data during the boot wait must be dropped
      host.put(3'b100, 16'h4000, 1'b0);
      check({14'h0, ready_w, early_w}, 16'h0001);
      for (int i = 0; i < 3; i++)
      begin
         step(16'h8000, gains[i], 16'h0000);
         check(dac_w.code, gexp[i]);
      end
      step(16'hFFFF, 16'hFFFF, 16'h7FFF);
      check(dac_w.code, 16'hFFFF);
      step(16'h0000, 16'h0000, 16'h8000);
      check(dac_w.code, 16'h0000);
      // Unity gain with a negative offset larger than the data
      step(16'h0010, 16'h8000, 16'hFF00);
      check(dac_w.code, 16'h0000);
      check(dac_n.code, 16'h0000);
      step(16'h0003, 16'h8003, 16'hFFFF);
      check(dac_n.code, 16'h0000);
      // A second word inside the gap is refused
      host.put(3'b100, 16'h1234, 1'b0);
      check({14'h0, early_w, early_n}, 16'h0003);
      repeat (3) @(posedge sys_clk_i);
      #1;
      check(dac_w.code, last_w);
      // Let the gap run out, then offer a word with the enable low: it must be lost
      repeat (45) @(posedge sys_clk_i);
      #1;
      clk_en = 1'b0;
      host.put(3'b100, 16'h2222, 1'b1);
      @(posedge sys_clk_i);
      #1;
      check({15'h0, dac_w.valid}, 16'h0000);
      check(dac_w.code, last_w);
      clk_en = 1'b1;
      repeat (3) @(posedge sys_clk_i);
      #1;
      check(dac_w.code, last_w);
      repeat (30) step(16'($urandom()), 16'($urandom()), 16'($urandom()));
      conclude();
   end
endmodule : dgc_code_path_tb
